// ---- design/lcdid_decoder.sv ----
/*
  lcdid_decoder: instruction decoder for the second half of an stn lcd controller command set.
  assumes: one byte strobe per cycle synchronous to clk_i, host polls busy_o before writes.
*/
`timescale 1ns/1ns

// Functional notes
// - bias bit with duty pins picks bias
// - modify-read: reads hold column, writes advance
// - capture column on entry, restore on exit
// - reset command restores line, column, page, scan
// - nibble 1100: bit3 sets common scan direction
// - power command stores converter/regulator/follower enables
// - ratio command loads regulator ratio, default 4
// - refv command: next byte is register update
// - refv byte bits 5..0 contrast, default 32
// - indicator command sets mode; when on, next byte register
// - indicator output off, 1s, 0.5s, steady
// - test codes cleared by hw reset or reset
// - all-on while display off enters power save
// - all-off leaves sleep or standby
// - sleep halts oscillator, power, drives ground; power enables still pass as stored here
// - standby halts power, duty drive; oscillator runs; power enables still pass as stored here
// - reset command in standby enters sleep
// - busy during operation or reset rejects bytes
// - all-points-on overrides ram and invert
module lcdid_decoder #(
  parameter int unsigned BLINK_SLOW = lcdid_pkg::BLINK_SLOW_CYC,
  parameter int unsigned BLINK_FAST = lcdid_pkg::BLINK_FAST_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // host byte port
  input  wire logic        strobe_i,
  input  wire logic        cmd_data_select_i,
  input  wire logic        read_write_i,
  input  wire logic [7:0]  data_i,
  // duty straps
  input  wire logic        duty_sel_hi_i,
  input  wire logic        duty_sel_lo_i,
  // status
  output logic             busy_o,
  output logic             modify_read_o,
  output logic             test_mode_o,
  output logic [1:0]       power_save_o,
  // addresses
  output logic [7:0]       column_o,
  output logic [3:0]       page_o,
  output logic [5:0]       start_line_o,
  // drive configuration
  output logic [3:0]       bias_den_o,
  output logic             common_scan_dir_o,
  output logic             converter_enable_o,
  output logic             regulator_enable_o,
  output logic             follower_enable_o,
  output logic [2:0]       reg_ratio_o,
  output logic [5:0]       contrast_o,
  output logic             indicator_mode_on_o,
  output logic [1:0]       indicator_state_o,
  output logic             indicator_o,
  output logic             all_points_on_o,
  output logic             invert_display_o,
  output logic             display_on_o,
  output logic             osc_run_o,
  output logic             drive_ground_o
);
  lcdid_pkg::lcdid_state_type state, next_state;

  function automatic logic [3:0] bias_of(input logic hi, input logic lo, input logic b);
    logic [3:0] r;
    r = lcdid_pkg::BIAS_9;
    unique case ({hi, lo})
      2'b00: r = b ? lcdid_pkg::BIAS_5 : lcdid_pkg::BIAS_6;
      2'b01, 2'b10: r = b ? lcdid_pkg::BIAS_6 : lcdid_pkg::BIAS_8;
      2'b11: r = b ? lcdid_pkg::BIAS_7 : lcdid_pkg::BIAS_9;
    endcase
    return r;
  endfunction

  logic cmd_byte;
  logic data_wr;
  logic data_rd;
  logic [7:0] d;

  always_comb begin
    d        = data_i;
    cmd_byte = strobe_i && !state.busy && !cmd_data_select_i && !read_write_i;
    data_wr  = strobe_i && !state.busy && cmd_data_select_i && !read_write_i;
    data_rd  = strobe_i && !state.busy && cmd_data_select_i && read_write_i;
    next_state = state;
    if (state.busy_cnt != 2'h0) begin
      next_state.busy_cnt = state.busy_cnt - 2'h1;
    end
    next_state.busy = (next_state.busy_cnt != 2'h0);
    next_state.bias_den = bias_of(duty_sel_hi_i, duty_sel_lo_i, state.bias_sel);

    if (data_wr) begin
      next_state.column = state.column + 8'h01;
    end else if (data_rd && !state.modify_read) begin
      next_state.column = state.column + 8'h01;
    end

    if (cmd_byte) begin
      if (state.seq == lcdid_pkg::LCDID_WAIT_REFV) begin
        next_state.contrast = d[5:0];
        next_state.seq      = lcdid_pkg::LCDID_IDLE;
      end else if (state.seq == lcdid_pkg::LCDID_WAIT_IND) begin
        next_state.indicator_state = d[1:0];
        next_state.seq             = lcdid_pkg::LCDID_IDLE;
      end else if (d[7:1] == lcdid_pkg::OPC_BIAS) begin
        next_state.bias_sel = d[0];
      end else if (d == lcdid_pkg::OPC_MR_SET) begin
        next_state.modify_read  = 1'b1;
        next_state.column_saved = state.column;
      end else if (d == lcdid_pkg::OPC_MR_CLR) begin
        next_state.modify_read = 1'b0;
        next_state.column      = state.column_saved;
      end else if (d == lcdid_pkg::OPC_RESET) begin
        next_state.start_line      = 6'h00;
        next_state.column          = 8'h00;
        next_state.page            = 4'h0;
        next_state.common_scan_dir = 1'b0;
        next_state.test_mode       = 1'b0;
        next_state.busy_cnt        = 2'(lcdid_pkg::BUSY_CYC);
        next_state.busy            = 1'b1;
        if (state.pwr == lcdid_pkg::LCDID_STANDBY) begin
          next_state.pwr = lcdid_pkg::LCDID_SLEEP;
        end
      end else if (d == lcdid_pkg::OPC_NOP) begin
        next_state.seq = lcdid_pkg::LCDID_IDLE;
      end else if (d[7:4] == lcdid_pkg::OPC_SCAN) begin
        next_state.common_scan_dir = d[3];
      end else if (d[7:3] == lcdid_pkg::OPC_POWER) begin
        next_state.power = lcdid_pkg::lcdid_power_type'(d[2:0]);
      end else if (d[7:3] == lcdid_pkg::OPC_RATIO) begin
        next_state.reg_ratio = d[2:0];
      end else if (d == lcdid_pkg::OPC_REFV) begin
        next_state.seq = lcdid_pkg::LCDID_WAIT_REFV;
      end else if (d[7:1] == lcdid_pkg::OPC_IND) begin
        next_state.indicator_mode_on = d[0];
        if (d[0]) begin
          next_state.seq = lcdid_pkg::LCDID_WAIT_IND;
        end
      end else if (d[7:1] == lcdid_pkg::OPC_ALLON) begin
        next_state.all_points_on = d[0];
        if (d[0] && !state.display_on) begin
          next_state.pwr = state.indicator_mode_on ? lcdid_pkg::LCDID_STANDBY
                                                   : lcdid_pkg::LCDID_SLEEP;
        end else if (!d[0]) begin
          next_state.pwr = lcdid_pkg::LCDID_RUN;
        end
      end else if (d[7:1] == lcdid_pkg::OPC_DISP) begin
        next_state.display_on = d[0];
      end else if (d[7:1] == lcdid_pkg::OPC_INVERT) begin
        next_state.invert_display = d[0];
      end else if (d[7:4] == lcdid_pkg::OPC_TEST1 || d[7:4] == lcdid_pkg::OPC_TEST2) begin
        next_state.test_mode = 1'b1;
      end else if (d[7:6] == 2'b01) begin
        next_state.start_line = d[5:0];
      end else if (d[7:4] == 4'hB) begin
        next_state.page = d[3:0];
      end else if (d[7:4] == 4'h1) begin
        next_state.column = {d[3:0], state.column[3:0]};
      end else if (d[7:4] == 4'h0) begin
        next_state.column = {state.column[7:4], d[3:0]};
      end
    end

    // indicator blink; standby stops the static drive too, from the very edge it is entered
    if (next_state.pwr != lcdid_pkg::LCDID_RUN) begin
      next_state.blink_cnt     = 26'h000_0000;
      next_state.indicator_out = 1'b0;
    end else begin
      unique case (state.indicator_state)
        2'b00: begin
          next_state.indicator_out = 1'b0;
          next_state.blink_cnt     = 26'h000_0000;
        end
        2'b11: begin
          next_state.indicator_out = 1'b1;
          next_state.blink_cnt     = 26'h000_0000;
        end
        default: begin
          if ({6'h00, state.blink_cnt} >= (state.indicator_state == 2'b01 ?
              BLINK_SLOW / 2 - 1 : BLINK_FAST / 2 - 1)) begin
            next_state.blink_cnt     = 26'h000_0000;
            next_state.indicator_out = !state.indicator_out;
          end else begin
            next_state.blink_cnt = state.blink_cnt + 26'h000_0001;
          end
        end
      endcase
    end

    next_state.osc_run      = (next_state.pwr != lcdid_pkg::LCDID_SLEEP);
    next_state.drive_ground = (next_state.pwr != lcdid_pkg::LCDID_RUN);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state                   <= '0;
      state.pwr               <= lcdid_pkg::LCDID_RUN;
      state.seq               <= lcdid_pkg::LCDID_IDLE;
      state.busy              <= 1'b1;
      state.busy_cnt          <= 2'(lcdid_pkg::BUSY_CYC);
      // follows the straps at once so the first edge after reset shows no stale bias
      state.bias_den          <= bias_of(duty_sel_hi_i, duty_sel_lo_i, 1'b0);
      state.reg_ratio         <= lcdid_pkg::RATIO_RESET;
      state.contrast          <= lcdid_pkg::CONTRAST_RESET;
      state.osc_run           <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // power outputs not gated while saving power: stored supply enables pass in every mode
  always_comb begin
    busy_o              = state.busy;
    modify_read_o       = state.modify_read;
    test_mode_o         = state.test_mode;
    power_save_o        = state.pwr;
    column_o            = state.column;
    page_o              = state.page;
    start_line_o        = state.start_line;
    bias_den_o          = state.bias_den;
    common_scan_dir_o   = state.common_scan_dir;
    converter_enable_o  = state.power.converter_enable;
    regulator_enable_o  = state.power.regulator_enable;
    follower_enable_o   = state.power.follower_enable;
    reg_ratio_o         = state.reg_ratio;
    contrast_o          = state.contrast;
    indicator_mode_on_o = state.indicator_mode_on;
    indicator_state_o   = state.indicator_state;
    indicator_o         = state.indicator_out;
    all_points_on_o     = state.all_points_on;
    invert_display_o    = state.invert_display && !state.all_points_on;
    display_on_o        = state.display_on;
    osc_run_o           = state.osc_run;
    drive_ground_o      = state.drive_ground;
  end

  chk_bias_pick: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 bias_den_o == bias_of($past(duty_sel_hi_i), $past(duty_sel_lo_i), $past(state.bias_sel)))
    else $error("bias mismatch");

  chk_mr_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (data_rd && state.modify_read && !cmd_byte) |=> $stable(column_o))
    else $error("column moved on modify read");

  chk_mr_restore: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmd_byte && data_i == lcdid_pkg::OPC_MR_CLR && state.seq == lcdid_pkg::LCDID_IDLE)
    |=> column_o == $past(state.column_saved))
    else $error("column not restored");

  chk_reset_cmd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmd_byte && data_i == lcdid_pkg::OPC_RESET && state.seq == lcdid_pkg::LCDID_IDLE)
    |=> column_o == 8'h00 && page_o == 4'h0 && !common_scan_dir_o && busy_o)
    else $error("reset command incomplete");

  sequence s_refv_open;
    cmd_byte && data_i == lcdid_pkg::OPC_REFV && state.seq == lcdid_pkg::LCDID_IDLE;
  endsequence
  sequence s_refv_byte;
    cmd_byte ##1 contrast_o == $past(data_i[5:0]);
  endsequence
  chk_refv_two: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_refv_open ##1 cmd_byte |-> ##1 contrast_o == $past(data_i[5:0])
                                     && state.seq == lcdid_pkg::LCDID_IDLE)
    else $error("reference byte not taken");

  chk_sleep_out: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    power_save_o == lcdid_pkg::LCDID_SLEEP |-> !osc_run_o && drive_ground_o)
    else $error("sleep outputs wrong");

  chk_busy_drop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (strobe_i && state.busy) |=> $stable(contrast_o) && $stable(page_o))
    else $error("byte accepted while busy");

  chk_standby_sleep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmd_byte && data_i == lcdid_pkg::OPC_RESET && state.seq == lcdid_pkg::LCDID_IDLE
     && power_save_o == lcdid_pkg::LCDID_STANDBY) |=> power_save_o == lcdid_pkg::LCDID_SLEEP)
    else $error("standby reset not sleeping");
endmodule

// ---- design/lcdid_pkg.sv ----
/*
  lcdid_pkg: constants, encodings and carrier types for the lcd instruction decoder.
  assumes: a single 50 MHz clock domain and an 8-bit instruction byte bus.
*/
package lcdid_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned BLINK_SLOW_MS   = 1000;
  localparam int unsigned BLINK_FAST_MS   = 500;
  localparam int unsigned BLINK_SLOW_CYC  = CLK_HZ / 1000 * BLINK_SLOW_MS;
  localparam int unsigned BLINK_FAST_CYC  = CLK_HZ / 1000 * BLINK_FAST_MS;
  localparam int unsigned BUSY_CYC        = 2;

  localparam logic [6:0] OPC_BIAS      = 7'h51;
  localparam logic [7:0] OPC_MR_SET    = 8'hE0;
  localparam logic [7:0] OPC_MR_CLR    = 8'hEE;
  localparam logic [7:0] OPC_RESET     = 8'hE2;
  localparam logic [7:0] OPC_NOP       = 8'hE3;
  localparam logic [3:0] OPC_SCAN      = 4'hC;
  localparam logic [4:0] OPC_POWER     = 5'h05;
  localparam logic [4:0] OPC_RATIO     = 5'h04;
  localparam logic [7:0] OPC_REFV      = 8'h81;
  localparam logic [6:0] OPC_IND       = 7'h56;
  localparam logic [6:0] OPC_ALLON     = 7'h52;
  localparam logic [6:0] OPC_DISP      = 7'h57;
  localparam logic [6:0] OPC_INVERT    = 7'h53;
  localparam logic [3:0] OPC_TEST1     = 4'hF;
  localparam logic [3:0] OPC_TEST2     = 4'h9;

  localparam logic [2:0] RATIO_RESET    = 3'h4;
  localparam logic [5:0] CONTRAST_RESET = 6'h20;

  // bias codes: 1/5 .. 1/9 denominator
  localparam logic [3:0] BIAS_5 = 4'h5;
  localparam logic [3:0] BIAS_6 = 4'h6;
  localparam logic [3:0] BIAS_7 = 4'h7;
  localparam logic [3:0] BIAS_8 = 4'h8;
  localparam logic [3:0] BIAS_9 = 4'h9;

  typedef enum logic [1:0] {LCDID_RUN, LCDID_SLEEP, LCDID_STANDBY} lcdid_pwr_type;
  typedef enum logic [1:0] {LCDID_IDLE, LCDID_WAIT_REFV, LCDID_WAIT_IND} lcdid_seq_type;

  typedef struct packed {
    logic converter_enable;
    logic regulator_enable;
    logic follower_enable;
  } lcdid_power_type;

  typedef struct packed {
    lcdid_pwr_type   pwr;
    lcdid_seq_type   seq;
    logic            busy;
    logic [1:0]      busy_cnt;
    logic            bias_sel;
    logic [3:0]      bias_den;
    logic            modify_read;
    logic [7:0]      column;
    logic [7:0]      column_saved;
    logic [3:0]      page;
    logic [5:0]      start_line;
    logic            common_scan_dir;
    lcdid_power_type power;
    logic [2:0]      reg_ratio;
    logic [5:0]      contrast;
    logic            indicator_mode_on;
    logic [1:0]      indicator_state;
    logic [25:0]     blink_cnt;
    logic            indicator_out;
    logic            test_mode;
    logic            display_on;
    logic            all_points_on;
    logic            invert_display;
    logic            osc_run;
    logic            drive_ground;
  } lcdid_state_type;
endpackage

// ---- dv/lcdid_host.sv ----
/*
  lcdid_host: host processor model issuing command and display data bytes.
  assumes: the decoder samples strobe_o on rising clk_i and reports busy_i.
*/
`timescale 1ns/1ns
module lcdid_host (
  // clock and status
  input  wire logic       clk_i,
  input  wire logic       busy_i,
  // byte port
  output logic            strobe_o,
  output logic            cmd_data_select_o,
  output logic            read_write_o,
  output logic [7:0]      data_o
);
  // extra idle cycles before each byte, for a slow host
  int idle_gap = 0;
  initial begin
    strobe_o = 1'b0;
    cmd_data_select_o = 1'b0;
    read_write_o = 1'b0;
    data_o = 8'h00;
  end
  // poll is dropped only where a refusal is to be provoked
  task automatic send(input logic sel, input logic rw, input logic [7:0] d, input bit poll);
    int n;
    n = 0;
    repeat (idle_gap) @(posedge clk_i);
    @(posedge clk_i);
    while (poll && busy_i !== 1'b0 && n < 100) begin
      n++;
      @(posedge clk_i);
    end
    cmd_data_select_o <= sel;
    read_write_o <= rw;
    data_o <= d;
    strobe_o <= 1'b1;
    @(posedge clk_i);
    strobe_o <= 1'b0;
    // a released bus must not keep showing the last byte
    data_o <= ~d;
  endtask
endmodule

// ---- dv/lcdid_decoder_tb.sv ----
/*
  lcdid_decoder_tb: self-checking bench for the lcd instruction decoder.
  assumes: lcdid_host drives the byte port; blink periods shortened to 20 and 10 cycles.
*/
`timescale 1ns/1ns
module lcdid_decoder_tb;
  localparam int SLOW = 20;
  localparam int FAST = 10;
  logic       clk_i, reset_n_i, strobe_i, cmd_data_select_i, read_write_i;
  logic [7:0] data_i, column_o;
  logic       duty_sel_hi_i, duty_sel_lo_i, busy_o, modify_read_o, test_mode_o;
  logic [1:0] power_save_o, indicator_state_o;
  logic [3:0] page_o, bias_den_o;
  logic [5:0] start_line_o, contrast_o;
  logic [2:0] reg_ratio_o;
  logic       common_scan_dir_o, converter_enable_o, regulator_enable_o, follower_enable_o;
  logic       indicator_mode_on_o, indicator_o, all_points_on_o, invert_display_o;
  logic       display_on_o, osc_run_o, drive_ground_o;
  int         err_total = 0;
  int         total_checks = 0;

  lcdid_decoder #(.BLINK_SLOW(SLOW), .BLINK_FAST(FAST)) i_lcdid_decoder (
    .clk_i, .reset_n_i, .strobe_i, .cmd_data_select_i, .read_write_i, .data_i,
    .duty_sel_hi_i, .duty_sel_lo_i, .busy_o, .modify_read_o, .test_mode_o,
    .power_save_o, .column_o, .page_o, .start_line_o, .bias_den_o, .common_scan_dir_o,
    .converter_enable_o, .regulator_enable_o, .follower_enable_o, .reg_ratio_o,
    .contrast_o, .indicator_mode_on_o, .indicator_state_o, .indicator_o,
    .all_points_on_o, .invert_display_o, .display_on_o, .osc_run_o, .drive_ground_o
  );
  lcdid_host i_lcdid_host (
    .clk_i, .busy_i(busy_o), .strobe_o(strobe_i), .cmd_data_select_o(cmd_data_select_i),
    .read_write_o(read_write_i), .data_o(data_i)
  );

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // results are looked at on the falling edge, after the taking edge has landed
  task automatic put(input logic sel, input logic rw, input logic [7:0] d);
    i_lcdid_host.send(sel, rw, d, 1'b1);
    @(negedge clk_i);
  endtask
  task automatic cmd(input logic [7:0] d);
    put(1'b0, 1'b0, d);
  endtask
  task automatic hw_reset;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
  endtask

  task automatic t_reset_values;
    chk("ratio", 8'h04, 8'(reg_ratio_o));
    chk("contrast", 8'h20, 8'(contrast_o));
    chk("busy", 8'h01, 8'(busy_o));
  endtask
  task automatic t_bias;
    logic [3:0] lo [4] = '{4'h6, 4'h8, 4'h8, 4'h9};
    logic [3:0] hi [4] = '{4'h5, 4'h6, 4'h6, 4'h7};
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      {duty_sel_hi_i, duty_sel_lo_i} <= k[2:1];
      cmd({7'h51, k[0]});
      @(negedge clk_i);
      chk("bias", 8'(k[0] ? hi[k[2:1]] : lo[k[2:1]]), 8'(bias_den_o));
    end
  endtask
  task automatic t_fields;
    for (int k = 0; k < 8; k++) begin
      cmd(8'h20 | 8'(k));
      cmd(8'h28 | 8'(k));
      cmd({4'hC, k[0], 3'(k)});
      chk("ratio", 8'(k), 8'(reg_ratio_o));
      chk("power", 8'(k), 8'({converter_enable_o, regulator_enable_o, follower_enable_o}));
      chk("scan", 8'(k[0]), 8'(common_scan_dir_o));
    end
  endtask
  task automatic t_pairs;
    cmd(8'h81);
    cmd(8'hE5);
    chk("contrast", 8'h25, 8'(contrast_o));
    cmd(8'h21);
    chk("ratio", 8'h01, 8'(reg_ratio_o));
    chk("contrast", 8'h25, 8'(contrast_o));
    put(1'b0, 1'b1, 8'h22);
    put(1'b1, 1'b0, 8'h23);
    chk("ratio", 8'h01, 8'(reg_ratio_o));
  endtask
  task automatic t_blink;
    int ones, flips;
    logic last;
    int per [4] = '{0, SLOW, FAST, 0};
    for (int s = 0; s < 4; s++) begin
      cmd(8'hAD);
      cmd(8'(s));
      // let the first, possibly short, half period pass before counting
      repeat (SLOW) @(negedge clk_i);
      ones = 0;
      flips = 0;
      last = indicator_o;
      repeat (2 * SLOW) begin
        @(negedge clk_i);
        ones += int'(indicator_o === 1'b1);
        flips += int'(indicator_o !== last);
        last = indicator_o;
      end
      chk("ind_on", 8'(s == 0 ? 0 : (s == 3 ? 2 * SLOW : SLOW)), 8'(ones));
      chk("ind_flips", 8'(per[s] == 0 ? 0 : 4 * SLOW / per[s]), 8'(flips));
    end
    cmd(8'h26);
    chk("ratio", 8'h06, 8'(reg_ratio_o));
    chk("ind_state", 8'h03, 8'(indicator_state_o));
    chk("ind_mode", 8'h01, 8'(indicator_mode_on_o));
  endtask
  task automatic t_modify;
    i_lcdid_host.idle_gap = 3;
    cmd(8'h11);
    cmd(8'h02);
    put(1'b1, 1'b1, 8'h00);
    chk("column", 8'h13, column_o);
    cmd(8'hE0);
    put(1'b1, 1'b1, 8'h00);
    chk("column", 8'h13, column_o);
    put(1'b1, 1'b0, 8'hAA);
    put(1'b1, 1'b0, 8'h55);
    chk("column", 8'h15, column_o);
    chk("mr", 8'h01, 8'(modify_read_o));
    cmd(8'hEE);
    chk("column", 8'h13, column_o);
    chk("mr", 8'h00, 8'(modify_read_o));
    i_lcdid_host.idle_gap = 0;
  endtask
  task automatic t_reset_cmd;
    cmd(8'h45);
    cmd(8'hB3);
    cmd(8'hC8);
    cmd(8'h2F);
    cmd(8'h23);
    cmd(8'hF0);
    chk("test", 8'h01, 8'(test_mode_o));
    cmd(8'hE2);
    chk("busy", 8'h01, 8'(busy_o));
    i_lcdid_host.send(1'b0, 1'b0, 8'h26, 1'b0);
    @(negedge clk_i);
    chk("ratio", 8'h03, 8'(reg_ratio_o));
    chk("line", 8'h00, 8'(start_line_o));
    chk("page", 8'h00, 8'(page_o));
    chk("column", 8'h00, column_o);
    chk("scan", 8'h00, 8'(common_scan_dir_o));
    chk("power", 8'h07, 8'({converter_enable_o, regulator_enable_o, follower_enable_o}));
    chk("test", 8'h00, 8'(test_mode_o));
    cmd(8'h9A);
    chk("test", 8'h01, 8'(test_mode_o));
    hw_reset();
    chk("test", 8'h00, 8'(test_mode_o));
  endtask
  task automatic t_power_save;
    cmd(8'hAE);
    cmd(8'hAC);
    cmd(8'h27);
    chk("ratio", 8'h07, 8'(reg_ratio_o));
    cmd(8'hA5);
    chk("save", 8'h01, 8'(power_save_o));
    chk("osc", 8'h00, 8'(osc_run_o));
    chk("ground", 8'h01, 8'(drive_ground_o));
    cmd(8'hA4);
    chk("save", 8'h00, 8'(power_save_o));
    chk("osc", 8'h01, 8'(osc_run_o));
    cmd(8'hAD);
    cmd(8'h03);
    cmd(8'hA5);
    chk("save", 8'h02, 8'(power_save_o));
    chk("osc", 8'h01, 8'(osc_run_o));
    chk("ground", 8'h01, 8'(drive_ground_o));
    chk("ind", 8'h00, 8'(indicator_o));
    cmd(8'hE2);
    chk("save", 8'h01, 8'(power_save_o));
    chk("osc", 8'h00, 8'(osc_run_o));
    cmd(8'hA4);
    chk("save", 8'h00, 8'(power_save_o));
    cmd(8'hAF);
    cmd(8'hA7);
    cmd(8'hA5);
    chk("save", 8'h00, 8'(power_save_o));
    chk("all_on", 8'h01, 8'(all_points_on_o));
    chk("invert", 8'h00, 8'(invert_display_o));
    cmd(8'hA4);
    chk("invert", 8'h01, 8'(invert_display_o));
  endtask

  task automatic end_of_test;
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    reset_n_i = 1'b0;
    duty_sel_hi_i = 1'b0;
    duty_sel_lo_i = 1'b0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    t_reset_values();
    t_bias();
    t_fields();
    t_pairs();
    t_blink();
    t_modify();
    t_reset_cmd();
    t_power_save();
    end_of_test();
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end
endmodule
